// [verilog/fbws_pkg.sv]
// package of offsets, fields and timing for the flash block write sequencer
package fbws_pkg;
	// register byte addresses on the apb bus
	localparam logic [7:0] ADDR_LATCH = 8'h00; // table byte latch
	localparam logic [7:0] ADDR_PTR = 8'h04; // program byte pointer
	localparam logic [7:0] ADDR_CTRL = 8'h08; // flash control register
	localparam logic [7:0] ADDR_UNLOCK = 8'h0c; // flash unlock register
	localparam logic [7:0] ADDR_TBLWR = 8'h10; // table write op trigger
	localparam logic [7:0] ADDR_HOLD = 8'h14; // holding latch readback at pointer
	// flash control register fields
	localparam int CTRL_WR_BIT = 1; // write start bit
	localparam int CTRL_FLASH_WRITE_ENABLE_BIT = 2; // flash write enable
	localparam int CTRL_BUSY_BIT = 3; // long write in progress
	// table write op command field
	localparam int TBLWR_PREINC_BIT = 0; // pre-increment pointer before write
	localparam int TBLWR_POSTINC_BIT = 1; // post-increment pointer after write
	// unlock key values
	localparam logic [7:0] UNLOCK_KEY1 = 8'h55;
	localparam logic [7:0] UNLOCK_KEY2 = 8'haa;
	// block geometry
	localparam int BLOCK_BYTES = 64;
	localparam int BLOCK_IDX_W = 6;
	localparam int PTR_W = 21;
	// programming time
	localparam int PROG_TIME_US = 3000;
	localparam int CLK_MHZ = 50;
	localparam int PROG_CYCLES = PROG_TIME_US * CLK_MHZ;
	// reset values
	localparam logic [7:0] LATCH_RST = 8'hff;
	localparam logic [PTR_W-1:0] PTR_RST = 21'h000000;
	// sequencer states
	typedef enum logic [3:0] {
		FBWS_IDLE = 4'b0001,
		FBWS_KEY1 = 4'b0010,
		FBWS_ARMED = 4'b0100,
		FBWS_PROG = 4'b1000
	} fbws_state_t;
endpackage

// [verilog/fbws_top.sv]
// flash block write sequencer: holding latches, unlock guard and timed long write
// Function
// - program only whole 64-byte blocks
// - provide 64 byte-wide holding latches
// - each table write moves one byte
// - table write touches only holding latch
// - array programmed only by long write
// - stall core during long write
// - internal timer ends long write
// - latches keep contents after programming
// - write enable bit 2 required
// - unlock writes 55h then aah
// - write bit after unlock starts programming
// - pointer selects target block at start
// - pointer is byte address, auto-advanced
module fbws_top #(
	parameter int PROG_CYCLES = fbws_pkg::PROG_CYCLES
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic reset_n,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// core side
	output logic core_stall,
	// flash array side
	output logic flash_prog,
	output logic [fbws_pkg::PTR_W-1:0] flash_block_addr,
	output logic [fbws_pkg::BLOCK_BYTES*8-1:0] flash_block_data,
	input wire logic flash_done
);
	logic [7:0] latch_q;
	logic [fbws_pkg::PTR_W-1:0] ptr_q;
	logic flash_write_enable_q;
	logic wr_q;
	logic [7:0] hold_q [fbws_pkg::BLOCK_BYTES];
	fbws_pkg::fbws_state_t state_q;
	logic [31:0] timer_q;
	logic [31:0] prdata_q;
	logic pready_q;
	logic pslverr_q;
	logic stall_q;
	logic prog_q;
	logic [fbws_pkg::PTR_W-1:0] blk_q;
	logic done_s1_q;
	logic done_s2_q;
	logic acc;
	logic wr_acc;
	logic rd_acc;
	logic tbl_wr;
	logic [fbws_pkg::PTR_W-1:0] wr_ptr;
	logic start;
	logic known;
	logic timer_end;

	// one access phase per transfer, answered with pready the cycle after
	assign acc = psel && penable && !pready_q;
	assign wr_acc = acc && pwrite;
	assign rd_acc = acc && !pwrite;
	assign tbl_wr = wr_acc && paddr == fbws_pkg::ADDR_TBLWR;
	assign known = paddr == fbws_pkg::ADDR_LATCH || paddr == fbws_pkg::ADDR_PTR
		|| paddr == fbws_pkg::ADDR_CTRL || paddr == fbws_pkg::ADDR_UNLOCK
		|| paddr == fbws_pkg::ADDR_TBLWR || paddr == fbws_pkg::ADDR_HOLD;
	// pre-increment variant uses the advanced pointer for the latch index
	assign wr_ptr = pwdata[fbws_pkg::TBLWR_PREINC_BIT] ? ptr_q + 1'b1 : ptr_q;
	// write bit only honoured when armed by unlock and enabled
	assign start = wr_acc && paddr == fbws_pkg::ADDR_CTRL && pwdata[fbws_pkg::CTRL_WR_BIT]
		&& pwdata[fbws_pkg::CTRL_FLASH_WRITE_ENABLE_BIT] && flash_write_enable_q && state_q == fbws_pkg::FBWS_ARMED;
	assign timer_end = state_q == fbws_pkg::FBWS_PROG && timer_q == 32'h0;

	// bus answer and read mux
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h0;
		end else begin
			pready_q <= acc;
			pslverr_q <= acc && !known;
			prdata_q <= 32'h0;
			if (rd_acc) begin
				case (paddr)
					fbws_pkg::ADDR_LATCH: prdata_q <= {24'h0, latch_q};
					fbws_pkg::ADDR_PTR: prdata_q <= {11'h0, ptr_q};
					fbws_pkg::ADDR_CTRL: prdata_q <= {28'h0, stall_q, flash_write_enable_q, wr_q, 1'b0};
					fbws_pkg::ADDR_HOLD: prdata_q <= {24'h0, hold_q[ptr_q[5:0]]};
					default: prdata_q <= 32'h0;
				endcase
			end
		end
	end

	// table byte latch
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			latch_q <= fbws_pkg::LATCH_RST;
		end else if (wr_acc && paddr == fbws_pkg::ADDR_LATCH) begin
			latch_q <= pwdata[7:0];
		end
	end

	// program byte pointer, loaded directly or advanced by a table write
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			ptr_q <= fbws_pkg::PTR_RST;
		end else if (wr_acc && paddr == fbws_pkg::ADDR_PTR) begin
			ptr_q <= pwdata[fbws_pkg::PTR_W-1:0];
		end else if (tbl_wr) begin
			ptr_q <= pwdata[fbws_pkg::TBLWR_POSTINC_BIT] ? wr_ptr + 1'b1 : wr_ptr;
		end
	end

	// holding latches: one per byte, never cleared by programming
	genvar gi;
	generate
		for (gi = 0; gi < fbws_pkg::BLOCK_BYTES; gi++) begin : g_hold
			always_ff @(posedge core_clk or negedge reset_n) begin
				if (!reset_n) begin
					hold_q[gi] <= fbws_pkg::LATCH_RST;
				end else if (tbl_wr && wr_ptr[5:0] == 6'(gi)) begin
					hold_q[gi] <= latch_q;
				end
			end
		end
	endgenerate

	// write enable and write bit of the control register
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			flash_write_enable_q <= 1'b0;
			wr_q <= 1'b0;
		end else begin
			if (wr_acc && paddr == fbws_pkg::ADDR_CTRL) begin
				flash_write_enable_q <= pwdata[fbws_pkg::CTRL_FLASH_WRITE_ENABLE_BIT];
			end
			if (start) begin
				wr_q <= 1'b1;
			end else if (timer_end) begin
				wr_q <= 1'b0;
			end
		end
	end

	// unlock guard and long write sequencer
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			state_q <= fbws_pkg::FBWS_IDLE;
			timer_q <= 32'h0;
			blk_q <= fbws_pkg::PTR_RST;
		end else begin
			case (state_q)
				fbws_pkg::FBWS_IDLE: begin
					if (wr_acc && paddr == fbws_pkg::ADDR_UNLOCK
						&& pwdata[7:0] == fbws_pkg::UNLOCK_KEY1) begin
						state_q <= fbws_pkg::FBWS_KEY1;
					end
				end
				fbws_pkg::FBWS_KEY1: begin
					if (wr_acc) begin
						state_q <= (paddr == fbws_pkg::ADDR_UNLOCK
							&& pwdata[7:0] == fbws_pkg::UNLOCK_KEY2)
							? fbws_pkg::FBWS_ARMED : fbws_pkg::FBWS_IDLE;
					end
				end
				fbws_pkg::FBWS_ARMED: begin
					if (start) begin
						state_q <= fbws_pkg::FBWS_PROG;
						timer_q <= 32'(PROG_CYCLES - 1);
						blk_q <= {ptr_q[fbws_pkg::PTR_W-1:6], 6'h00};
					end else if (wr_acc) begin
						state_q <= fbws_pkg::FBWS_IDLE;
					end
				end
				fbws_pkg::FBWS_PROG: begin
					if (timer_end) begin
						state_q <= fbws_pkg::FBWS_IDLE;
					end else begin
						timer_q <= timer_q - 32'h1;
					end
				end
				default: state_q <= fbws_pkg::FBWS_IDLE;
			endcase
		end
	end

	// core stall and flash array strobes follow the programming state
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			stall_q <= 1'b0;
			prog_q <= 1'b0;
			done_s1_q <= 1'b0;
			done_s2_q <= 1'b0;
		end else begin
			done_s1_q <= flash_done;
			done_s2_q <= done_s1_q;
			stall_q <= start || (state_q == fbws_pkg::FBWS_PROG && !timer_end);
			prog_q <= start;
		end
	end

	// block data image from the holding latches
	generate
		for (gi = 0; gi < fbws_pkg::BLOCK_BYTES; gi++) begin : g_data
			assign flash_block_data[gi*8 +: 8] = hold_q[gi];
		end
	endgenerate

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign core_stall = stall_q;
	assign flash_prog = prog_q;
	assign flash_block_addr = blk_q;
endmodule // fbws_top

// [testbench/fbws_props.sv]
// port checker for the flash block write sequencer
module fbws_props #(
	parameter int PROG_CYCLES = 20
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic reset_n,
	// apb
	input wire logic psel,
	input wire logic penable,
	input wire logic [7:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// sequencer outputs
	input wire logic core_stall,
	input wire logic flash_prog,
	input wire logic [fbws_pkg::PTR_W-1:0] flash_block_addr
);
	logic [31:0] cnt_q;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!reset_n);
	// counts cycles of stall
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) cnt_q <= '0;
		else cnt_q <= core_stall ? cnt_q + 32'h1 : '0;
	end
	rdy_wait_a: assert property (psel && penable && !pready |=> pready)
		else $error("pready late");
	rdy_pulse_a: assert property (pready |=> !pready) else $error("pready too long");
	err_rdy_a: assert property (pslverr |-> pready) else $error("pslverr alone");
	rdata_idle_a: assert property (!pready |-> prdata == 32'h0) else $error("prdata idle");
	start_pair_a: assert property ($rose(core_stall) |-> flash_prog)
		else $error("stall without start");
	prog_cause_a: assert property (flash_prog |-> $past(paddr) == fbws_pkg::ADDR_CTRL)
		else $error("start without control write");
	blk_align_a: assert property (flash_prog |-> flash_block_addr[5:0] == 6'h0)
		else $error("block not aligned");
	stall_len_a: assert property ($fell(core_stall) |-> cnt_q == PROG_CYCLES)
		else $error("stall length wrong");
	cover property (flash_prog);
	cover property (pslverr);
	cover property ($fell(core_stall));
endmodule // fbws_props
bind fbws_top fbws_props #(.PROG_CYCLES(PROG_CYCLES)) u_props (.*);

// [testbench/fbws_flash_model.sv]
// flash array model that captures each programmed block
module fbws_flash_model (
	// clock and reset
	input wire logic core_clk,
	input wire logic reset_n,
	// array side
	input wire logic flash_prog,
	input wire logic [fbws_pkg::PTR_W-1:0] flash_block_addr,
	input wire logic [511:0] flash_block_data,
	output logic flash_done,
	// captured block
	output logic [fbws_pkg::PTR_W-1:0] got_addr,
	output logic [511:0] got_data
);
	// capture on start, answer done next cycle
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			flash_done <= 1'b0;
			got_addr <= '0;
			got_data <= '0;
		end else begin
			flash_done <= flash_prog;
			if (flash_prog) got_addr <= flash_block_addr;
			if (flash_prog) got_data <= flash_block_data;
		end
	end
endmodule // fbws_flash_model

// [testbench/testbench.sv]
// self-checking bench for the flash block write sequencer
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic core_clk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
	logic core_stall, flash_prog, flash_done, er;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic [20:0] flash_block_addr, got_addr;
	logic [511:0] flash_block_data, got_data, exp_data;
	int err_count = 0, samples_checked = 0;
	// 50 mhz clock
	always #10 core_clk = ~core_clk;
	fbws_top #(.PROG_CYCLES(20)) DUT (.*);
	fbws_flash_model u_flash (.*);
	task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			$display("BAD %s exp %h got %h", s, e, g);
			err_count++;
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n = 0;
		@(posedge core_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		do begin
			@(posedge core_clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin
			$display("BAD pready exp 1 got %b", pready);
			err_count++;
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic unlock;
		apb(1'b1, fbws_pkg::ADDR_UNLOCK, 32'h55);
		apb(1'b1, fbws_pkg::ADDR_UNLOCK, 32'haa);
	endtask
	task automatic guard;
		apb(1'b1, fbws_pkg::ADDR_CTRL, 32'h6);
		unlock();
		apb(1'b1, fbws_pkg::ADDR_CTRL, 32'h2);
		apb(1'b0, fbws_pkg::ADDR_CTRL, 32'h0);
		chk("guard", 32'h0, 32'(core_stall) | (rd & 32'ha));
		$display("test guard done");
	endtask
	task automatic fill;
		apb(1'b1, fbws_pkg::ADDR_PTR, 32'h3f);
		for (int i = 0; i < 64; i++) begin
			exp_data[8*i +: 8] = 8'(i) ^ 8'ha5;
			apb(1'b1, fbws_pkg::ADDR_LATCH, {24'h0, exp_data[8*i +: 8]});
			apb(1'b1, fbws_pkg::ADDR_TBLWR, 32'h1);
		end
		apb(1'b0, fbws_pkg::ADDR_HOLD, 32'h0);
		chk("hold", 32'h9a, rd);
		chk("latches", 32'h1, 32'(flash_block_data === exp_data));
		$display("test fill done");
	endtask
	task automatic prog;
		int n = 0;
		apb(1'b1, fbws_pkg::ADDR_CTRL, 32'h4);
		unlock();
		apb(1'b1, fbws_pkg::ADDR_CTRL, 32'h6);
		while (core_stall !== 1'b1 && n < 4) begin
			@(posedge core_clk);
			n++;
		end
		chk("stall", 32'h1, 32'(core_stall));
		apb(1'b0, fbws_pkg::ADDR_CTRL, 32'h0);
		chk("busy", 32'he, rd);
		while (core_stall !== 1'b0 && n < 100) begin
			@(posedge core_clk);
			n++;
		end
		chk("end", 32'h0, 32'(core_stall));
		chk("addr", 32'h40, 32'(got_addr));
		chk("data", 32'h1, 32'(got_data === exp_data));
		apb(1'b0, fbws_pkg::ADDR_CTRL, 32'h0);
		chk("wr", 32'h0, rd & 32'ha);
		chk("kept", 32'h1, 32'(flash_block_data === exp_data));
		apb(1'b0, 8'h18, 32'h0);
		chk("slverr", 32'h1, 32'(er));
		$display("test prog done");
	endtask
	task automatic conclude;
		$display("checks %0d mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	// main sequence
	initial begin
		repeat (6) @(posedge core_clk);
		reset_n <= 1'b1;
		guard();
		fill();
		prog();
		conclude();
	end
	// watchdog
	initial begin
		repeat (5000) @(posedge core_clk);
		err_count++;
		conclude();
	end
endmodule // testbench
